// file: design/fault_stop_params.svh
// constants for the stop-on-fault response block
`ifndef FAULT_STOP_PARAMS_SVH
`define FAULT_STOP_PARAMS_SVH
`define CLK_PERIOD_NS     8
`define OT_HOLD_MS        10
`define OT_HOLD_CYCLES    ((`OT_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
`define OT_CNT_W          21
`define DEMAND_W          8
`define FLT_BSUV          0
`define FLT_OT            1
`define FLT_LOS           2
`define FLT_VDS           3
`define FLT_N             4
`endif

// file: design/fault_stop_pkg.sv
// types for the stop-on-fault response block
package fault_stop_pkg;
	typedef enum logic [1:0] {
		OT_IDLE  = 2'b00,
		OT_HELD  = 2'b01,
		OT_DELAY = 2'b10
	} ot_state_e;
endpackage

// file: design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	logic s1_r, s2_r, s3_r, level_r, level_nxt;

	always_comb begin
		level_nxt = (s2_r == s3_r) ? s3_r : level_r;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_r <= 1'b0;
		end else begin
			s1_r    <= pin;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule

// file: design/fault_stop.sv
// fault response logic, stop-on-fault mode
// Function
// - stop selected: bootstrap uv, overtemp, vds or sync loss drive all gates low
// - latched faults other than overtemp clear when demand is zero or run is written 0
// - status/diagnostic read clears latched faults other than overtemp, only while read-reset disable is 0
// - overtemp latches, stops regulator, resets host; clears 10 ms after removal
// - temperature warning never disables or latches; indication follows condition
`timescale 1ns/1ps
`include "fault_stop_params.svh"
module fault_response_stop_mode #(
	parameter int unsigned OT_HOLD = `OT_HOLD_CYCLES
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	// fault detector pins
	input  wire logic                 bootstrap_uv_pin,
	input  wire logic                 temp_warn_pin,
	input  wire logic                 overtemp_pin,
	input  wire logic                 sync_loss_pin,
	input  wire logic                 drain_source_voltage_pin,
	// configuration and control
	input  wire logic                 stop_on_fault_select,
	input  wire logic                 diag_read_reset_dis,
	input  wire logic                 run_bit,
	input  wire logic [`DEMAND_W-1:0] demand,
	input  wire logic                 status_read,
	// outputs
	output logic                      gate_enable,
	output logic [`FLT_N-1:0]         fault_latched,
	output logic                      temp_warn_flag,
	output logic                      logic_supply_regulator_en,
	output logic                      host_reset_out_n
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [`FLT_N-1:0] det;
	logic [`FLT_N-1:0] det_pin;
	logic              tw;
	assign det_pin = {drain_source_voltage_pin, sync_loss_pin, overtemp_pin, bootstrap_uv_pin};

	genvar gi;
	generate
		for (gi = 0; gi < `FLT_N; gi++) begin : g_sync
			pin_sync u_sync (
				.mclk   (mclk),
				.resetn (resetn),
				.pin    (det_pin[gi]),
				.level  (det[gi])
			);
		end
	endgenerate

	pin_sync u_tw (
		.mclk   (mclk),
		.resetn (resetn),
		.pin    (temp_warn_pin),
		.level  (tw)
	);

	// ****************************************
	// fault latches and gate control
	// ****************************************
	logic [`FLT_N-1:0] lat_r, lat_nxt;
	logic              gate_r, gate_nxt, tw_r, tw_nxt;
	logic              run_d_r, dem_zero_r, armed_r, armed_nxt;
	logic              clr_ctrl, clr_read, dem_zero;
	fault_stop_pkg::ot_state_e ot_r, ot_nxt;
	logic [`OT_CNT_W-1:0] cnt_r, cnt_nxt;

	assign dem_zero = (demand == '0);
	assign clr_ctrl = dem_zero || !run_bit;
	assign clr_read = status_read && !diag_read_reset_dis;

	always_comb begin
		lat_nxt = lat_r;
		for (int i = 0; i < `FLT_N; i++) begin
			if (i != `FLT_OT && (clr_ctrl || clr_read))
				lat_nxt[i] = 1'b0;
		end
		// set wins over clear: a live detector re-latches
		if (stop_on_fault_select)
			lat_nxt = lat_nxt | (det & ~(`FLT_N'(1) << `FLT_OT));
		lat_nxt[`FLT_OT] = (ot_r != fault_stop_pkg::OT_IDLE) || det[`FLT_OT];
		// re-enable needs a fresh run rise or demand leaving zero;
		// any latched fault disarms, so a read clear alone never restarts the bridge
		armed_nxt = armed_r;
		if (clr_ctrl || (lat_nxt != '0))
			armed_nxt = 1'b0;
		else if ((run_bit && !run_d_r) || (!dem_zero && dem_zero_r))
			armed_nxt = 1'b1;
		gate_nxt = armed_nxt && run_bit && !dem_zero && (lat_nxt == '0);
		tw_nxt   = tw;
	end

	// ****************************************
	// overtemperature hold timer
	// ****************************************
	always_comb begin
		ot_nxt  = ot_r;
		cnt_nxt = cnt_r;
		case (ot_r)
			fault_stop_pkg::OT_IDLE: begin
				if (det[`FLT_OT])
					ot_nxt = fault_stop_pkg::OT_HELD;
			end
			fault_stop_pkg::OT_HELD: begin
				cnt_nxt = '0;
				if (!det[`FLT_OT])
					ot_nxt = fault_stop_pkg::OT_DELAY;
			end
			fault_stop_pkg::OT_DELAY: begin
				if (det[`FLT_OT])
					ot_nxt = fault_stop_pkg::OT_HELD;
				else if (cnt_r == `OT_CNT_W'(OT_HOLD - 1))
					ot_nxt = fault_stop_pkg::OT_IDLE;
				else
					cnt_nxt = cnt_r + `OT_CNT_W'(1);
			end
			default: ot_nxt = fault_stop_pkg::OT_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lat_r      <= '0;
			gate_r     <= 1'b0;
			tw_r       <= 1'b0;
			run_d_r    <= 1'b0;
			dem_zero_r <= 1'b1;
			armed_r    <= 1'b0;
			ot_r       <= fault_stop_pkg::OT_IDLE;
			cnt_r      <= '0;
		end else begin
			lat_r      <= lat_nxt;
			gate_r     <= gate_nxt;
			tw_r       <= tw_nxt;
			run_d_r    <= run_bit;
			dem_zero_r <= dem_zero;
			armed_r    <= armed_nxt;
			ot_r       <= ot_nxt;
			cnt_r      <= cnt_nxt;
		end
	end

	// ****************************************
	// regulator and host reset
	// ****************************************
	// both follow the overtemp latch; host held in reset until the first edge after resetn is released
	logic reg_en_r, reg_en_nxt, hrst_n_r, hrst_n_nxt;

	always_comb begin
		reg_en_nxt = !lat_nxt[`FLT_OT];
		hrst_n_nxt = !lat_nxt[`FLT_OT];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_en_r <= 1'b1;
			hrst_n_r <= 1'b0;
		end else begin
			reg_en_r <= reg_en_nxt;
			hrst_n_r <= hrst_n_nxt;
		end
	end

	assign gate_enable               = gate_r;
	assign fault_latched             = lat_r;
	assign temp_warn_flag            = tw_r;
	assign logic_supply_regulator_en = reg_en_r;
	assign host_reset_out_n          = hrst_n_r;

	// ****************************************
	// assertions
	// ****************************************
	a_gate_off_fault: assert property (@(posedge mclk) disable iff (!resetn)
		(stop_on_fault_select && det != '0) |=> !gate_enable)
		else $error("gate on during fault");

	a_gate_needs_run: assert property (@(posedge mclk) disable iff (!resetn)
		(demand == '0 || !run_bit) |=> !gate_enable)
		else $error("gate on without run or demand");

	a_ctrl_clears: assert property (@(posedge mclk) disable iff (!resetn)
		(clr_ctrl && stop_on_fault_select && (det == '0)) |=> (fault_latched[`FLT_VDS] == 1'b0))
		else $error("control clear ignored");

	a_read_clears: assert property (@(posedge mclk) disable iff (!resetn)
		(status_read && !diag_read_reset_dis && det == '0)
		|=> !(fault_latched[`FLT_BSUV] || fault_latched[`FLT_LOS] || fault_latched[`FLT_VDS]))
		else $error("read clear ignored");

	a_read_blocked: assert property (@(posedge mclk) disable iff (!resetn)
		(fault_latched[`FLT_VDS] && status_read && diag_read_reset_dis && !clr_ctrl)
		|=> fault_latched[`FLT_VDS])
		else $error("read cleared while disabled");

	a_read_no_restart: assert property (@(posedge mclk) disable iff (!resetn)
		(status_read && fault_latched != '0 && $past(run_bit) && !$past(dem_zero)) |=> !gate_enable)
		else $error("read clear restarted gates");

	a_run_rearm: assert property (@(posedge mclk) disable iff (!resetn)
		(gate_enable == 1'b0 && $rose(run_bit) && !dem_zero && det == '0 && fault_latched == '0)
		##1 (run_bit && !dem_zero && det == '0 && lat_r == '0) |-> ##0 gate_enable)
		else $error("run restart failed");

	a_ot_reset: assert property (@(posedge mclk) disable iff (!resetn)
		det[`FLT_OT] |=> (!host_reset_out_n && !logic_supply_regulator_en && !gate_enable))
		else $error("overtemp actions missing");

	a_ot_hold: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(det[`FLT_OT]) |=> !host_reset_out_n[*8])
		else $error("overtemp released early");

	a_warn_only: assert property (@(posedge mclk) disable iff (!resetn)
		(tw && det == '0 && lat_r == '0 && armed_r && run_bit && !dem_zero) |=> gate_enable)
		else $error("warning stopped gates");

	a_warn_no_latch: assert property (@(posedge mclk) disable iff (!resetn)
		(tw && det == '0 && fault_latched == '0) |=> (fault_latched == '0))
		else $error("warning latched a fault");

	// ****************************************
	// cover points
	// ****************************************
	c_fault_stop: cover property (@(posedge mclk) disable iff (!resetn) gate_enable ##1 !gate_enable);
	c_ot_release: cover property (@(posedge mclk) disable iff (!resetn) $rose(host_reset_out_n));
	c_read_clear: cover property (@(posedge mclk) disable iff (!resetn) clr_read && lat_r != '0);
	c_run_restart: cover property (@(posedge mclk) disable iff (!resetn) $rose(run_bit) ##1 gate_enable);
endmodule

// file: bench/fault_env.sv
// detector stand-in: raises and drops fault pins on request
`timescale 1ns/1ps
`include "fault_stop_params.svh"
module fault_env (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// requests from the bench
	input  wire logic [`FLT_N-1:0] flt_req,
	input  wire logic              warn_req,
	// detector pins
	output logic                   bootstrap_uv_pin,
	output logic                   temp_warn_pin,
	output logic                   overtemp_pin,
	output logic                   sync_loss_pin,
	output logic                   drain_source_voltage_pin
);
	logic [4:0] pins_r;
	// registered so pin edges never land on the sampling edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) pins_r <= 5'h00;
		else pins_r <= {warn_req, flt_req};
	end
	assign bootstrap_uv_pin         = pins_r[`FLT_BSUV];
	assign overtemp_pin             = pins_r[`FLT_OT];
	assign sync_loss_pin            = pins_r[`FLT_LOS];
	assign drain_source_voltage_pin = pins_r[`FLT_VDS];
	assign temp_warn_pin            = pins_r[4];
endmodule

// file: bench/fault_stop_tb.sv
// self-checking bench for the stop-on-fault response block
`timescale 1ns/1ps
`include "fault_stop_params.svh"
module fault_response_stop_mode_tb;
	logic                 mclk = 1'b0;
	logic                 resetn = 1'b0;
	logic [`FLT_N-1:0]    flt_req = 4'h0;
	logic                 warn_req = 1'b0;
	logic                 dis = 1'b0;
	logic                 run = 1'b0;
	logic                 rd = 1'b0;
	logic [`DEMAND_W-1:0] dem = 8'h00;
	logic                 bsuv, tw, ot, los, drain_source_voltage, gate, twf, reg_en, hrst_n;
	logic [`FLT_N-1:0]    lat;
	int                   n_mismatch = 0;
	int                   n_checks = 0;
	always #4 mclk = ~mclk;
	fault_env i_env (.mclk(mclk), .resetn(resetn), .flt_req(flt_req), .warn_req(warn_req),
		.bootstrap_uv_pin(bsuv), .temp_warn_pin(tw), .overtemp_pin(ot), .sync_loss_pin(los),
		.drain_source_voltage_pin(drain_source_voltage));
	fault_response_stop_mode #(.OT_HOLD(20)) i_dut (.mclk(mclk), .resetn(resetn), .bootstrap_uv_pin(bsuv),
		.temp_warn_pin(tw), .overtemp_pin(ot), .sync_loss_pin(los), .drain_source_voltage_pin(drain_source_voltage),
		.stop_on_fault_select(1'b1), .diag_read_reset_dis(dis), .run_bit(run), .demand(dem),
		.status_read(rd), .gate_enable(gate), .fault_latched(lat), .temp_warn_flag(twf),
		.logic_supply_regulator_en(reg_en), .host_reset_out_n(hrst_n));
	// ****************
	// helpers
	// ****************
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	// bounded: a gate that never moves ends the run
	task automatic wait_gate(input logic v);
		int k;
		k = 0;
		@(negedge mclk);
		while (gate !== v && k < 40) begin
			@(negedge mclk);
			k++;
		end
		chk("gate_enable", v, gate);
		if (k == 40) stop_test();
	endtask
	task automatic pulse_read(input logic d);
		@(posedge mclk) begin dis <= d; rd <= 1'b1; end
		@(posedge mclk) rd <= 1'b0;
		cyc(2);
	endtask
	initial begin
		cyc(12);
		@(posedge mclk) resetn <= 1'b1;
		cyc(1);
		chk("host_reset_out_n", 1, hrst_n);
		@(posedge mclk) begin run <= 1'b1; dem <= 8'h05; end
		wait_gate(1'b1);
		for (int i = 0; i < `FLT_N; i++) begin
			if (i == `FLT_OT) continue;
			@(posedge mclk) flt_req[i] <= 1'b1;
			wait_gate(1'b0);
			chk("fault_latched", 4'h1 << i, lat);
			@(posedge mclk) flt_req[i] <= 1'b0;
			cyc(8);
			if (i == `FLT_VDS) begin
				pulse_read(1'b1);
				chk("fault_latched", 4'h1 << i, lat);
				pulse_read(1'b0);
				chk("fault_latched", 4'h0, lat);
				chk("gate_enable", 4'h0, gate);
				@(posedge mclk) dem <= 8'h00;
			end else if (i == `FLT_LOS) @(posedge mclk) run <= 1'b0;
			else @(posedge mclk) dem <= 8'h00;
			cyc(2);
			chk("fault_latched", 4'h0, lat);
			@(posedge mclk) begin run <= 1'b1; dem <= 8'hff; end
			wait_gate(1'b1);
		end
		@(posedge mclk) warn_req <= 1'b1;
		cyc(8);
		chk("temp_warn_flag", 1, twf);
		chk("gate_enable", 1, gate);
		chk("fault_latched", 4'h0, lat);
		@(posedge mclk) warn_req <= 1'b0;
		cyc(8);
		chk("temp_warn_flag", 0, twf);
		@(posedge mclk) flt_req[`FLT_OT] <= 1'b1;
		wait_gate(1'b0);
		chk("host_reset_out_n", 0, hrst_n);
		chk("regulator_en", 0, reg_en);
		@(posedge mclk) flt_req[`FLT_OT] <= 1'b0;
		cyc(12);
		chk("fault_latched", 4'h1 << `FLT_OT, lat);
		cyc(24);
		chk("host_reset_out_n", 1, hrst_n);
		chk("fault_latched", 4'h0, lat);
		chk("regulator_en", 4'h1, reg_en);
		chk("gate_enable", 4'h0, gate);
		@(posedge mclk) run <= 1'b0;
		@(posedge mclk) run <= 1'b1;
		wait_gate(1'b1);
		stop_test();
	end
endmodule
